// [rtl/dtc_defines.vh]
// constants for the dual 8-bit timer counter
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// register file addresses (4-bit data)
`define DTC_RF_PORT_SEL 7'h0B
`define DTC_RF_T0_MODE 7'h11
`define DTC_RF_T1_MODE 7'h12

// mode register fields
`define DTC_MODE_RUN 3
`define DTC_MODE_CLR 2
`define DTC_MODE_CK_HI 1
`define DTC_MODE_CK_LO 0
`define DTC_MODE_RESET 4'h0

// port select register field
`define DTC_PSEL_TOGGLE 3

// clock select codes
`define DTC_CK_DIV256 2'h0
`define DTC_CK_DIV64 2'h1
`define DTC_CK_DIV16 2'h2
`define DTC_CK_ALT 2'h3

// prescaler masks, the tick fires when the masked bits are all ones
`define DTC_PRE_M256 8'hFF
`define DTC_PRE_M64 8'h3F
`define DTC_PRE_M16 8'h0F

// peripheral (8-bit) addresses
`define DTC_PER_MOD0 2'h0
`define DTC_PER_MOD1 2'h1
`define DTC_PER_CNT0 2'h2
`define DTC_PER_CNT1 2'h3

`endif

// [rtl/dtc_unit.v]
// one 8-bit count register with modulo compare
`timescale 1ns/1ns
module dtc_unit (
	// clock and reset
	input wire i_clk,
	input wire i_rst,
	// control
	input wire i_clear,
	input wire i_run,
	input wire i_pulse,
	// modulo write
	input wire i_mod_wr,
	input wire [7:0] i_mod_wdata,
	// status
	output reg [7:0] o_count,
	output wire o_equal,
	output reg o_wrap
);
	reg [7:0] modulo_r;

	assign o_equal = (o_count == modulo_r);

	always @(posedge i_clk) begin
		if (i_rst) begin
			modulo_r <= 8'h00;
		end else if (i_mod_wr) begin
			modulo_r <= i_mod_wdata;
		end
	end

	always @(posedge i_clk) begin
		if (i_rst) begin
			o_count <= 8'h00;
			o_wrap <= 1'b0;
		end else begin
			o_wrap <= 1'b0;
			if (i_clear) begin
				o_count <= 8'h00;
			end else if (i_run && i_pulse) begin
				if (o_equal) begin
					o_count <= 8'h00;
					o_wrap <= 1'b1;
				end else begin
					o_count <= o_count + 8'h01;
				end
			end
		end
	end
endmodule // dtc_unit

// [rtl/dtc_timer_pair.v]
// two 8-bit timer counters with mode registers and toggle output
`timescale 1ns/1ns
`include "dtc_defines.vh"

module dtc_timer_pair (
	// clock and reset
	input wire i_clk,
	input wire i_rst,
	// register file port (4-bit)
	input wire [6:0] i_rf_addr,
	input wire i_rf_wr,
	input wire i_rf_rd,
	input wire [3:0] i_rf_wdata,
	output reg [3:0] o_rf_rdata,
	// peripheral port (8-bit)
	input wire [1:0] i_per_addr,
	input wire i_per_wr,
	input wire i_per_rd,
	input wire [7:0] i_per_wdata,
	output reg [7:0] o_per_rdata,
	// external interrupt pin, synchronous
	input wire i_int_pin,
	// interrupt acknowledge from the cpu
	input wire [1:0] i_irq_ack,
	// interrupt request flags
	output reg o_first_timer_irq_flag,
	output reg o_second_timer_irq_flag,
	// toggle output pin, enable low while driving
	output reg o_first_timer_toggle_out,
	output reg o_toggle_out_oe_n
);
	reg [7:0] pre_r;
	reg int_prev_r;
	reg [1:0] run_r;
	reg [1:0] clear_r;
	reg [3:0] clksel_r;
	reg toggle_out_select_r;
	wire [15:0] count_w;
	wire [1:0] wrap_w;
	wire [1:0] alt_w;
	wire int_edge;
	wire t0_mode_wr;
	wire t1_mode_wr;
	wire psel_wr;

	// count pulse for one clock select code
	function pick_pulse;
		input [1:0] sel;
		input [7:0] pre;
		input alt;
		begin
			case (sel)
				`DTC_CK_DIV256: pick_pulse = (pre & `DTC_PRE_M256) ==
					`DTC_PRE_M256;
				`DTC_CK_DIV64: pick_pulse = (pre & `DTC_PRE_M64) ==
					`DTC_PRE_M64;
				`DTC_CK_DIV16: pick_pulse = (pre & `DTC_PRE_M16) ==
					`DTC_PRE_M16;
				default: pick_pulse = alt;
			endcase
		end
	endfunction

	// mode read: clear bit always reads zero
	function [3:0] mode_read;
		input run;
		input [1:0] sel;
		begin
			mode_read = {run, 1'b0, sel};
		end
	endfunction

	// register file address decode
	function rf_hit;
		input [6:0] addr;
		input [6:0] target;
		begin
			rf_hit = (addr == target);
		end
	endfunction

	assign int_edge = i_int_pin & ~int_prev_r;
	assign alt_w = {wrap_w[0], int_edge};
	assign t0_mode_wr = i_rf_wr && rf_hit(i_rf_addr, `DTC_RF_T0_MODE);
	assign t1_mode_wr = i_rf_wr && rf_hit(i_rf_addr, `DTC_RF_T1_MODE);
	assign psel_wr = i_rf_wr && rf_hit(i_rf_addr, `DTC_RF_PORT_SEL);

	always @(posedge i_clk) begin
		if (i_rst) begin
			pre_r <= 8'h00;
			int_prev_r <= 1'b0;
		end else begin
			pre_r <= pre_r + 8'h01;
			int_prev_r <= i_int_pin;
		end
	end

	// mode registers
	always @(posedge i_clk) begin
		if (i_rst) begin
			run_r <= 2'h0;
			clear_r <= 2'h0;
			clksel_r <= 4'h0;
			toggle_out_select_r <= 1'b0;
		end else begin
			clear_r <= 2'h0;
			if (t0_mode_wr) begin
				run_r[0] <= i_rf_wdata[`DTC_MODE_RUN];
				clear_r[0] <= i_rf_wdata[`DTC_MODE_CLR];
				clksel_r[1:0] <= i_rf_wdata[`DTC_MODE_CK_HI:
					`DTC_MODE_CK_LO];
			end
			if (t1_mode_wr) begin
				run_r[1] <= i_rf_wdata[`DTC_MODE_RUN];
				clear_r[1] <= i_rf_wdata[`DTC_MODE_CLR];
				clksel_r[3:2] <= i_rf_wdata[`DTC_MODE_CK_HI:
					`DTC_MODE_CK_LO];
			end
			if (psel_wr) begin
				toggle_out_select_r <= i_rf_wdata[`DTC_PSEL_TOGGLE];
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_tmr
			dtc_unit u_unit (
				.i_clk(i_clk),
				.i_rst(i_rst),
				.i_clear(clear_r[gi]),
				.i_run(run_r[gi]),
				.i_pulse(pick_pulse(clksel_r[2*gi+1:2*gi], pre_r,
					alt_w[gi])),
				.i_mod_wr(i_per_wr && (i_per_addr == gi)),
				.i_mod_wdata(i_per_wdata),
				.o_count(count_w[8*gi+7:8*gi]),
				.o_equal(),
				.o_wrap(wrap_w[gi])
			);
		end
	endgenerate

	// interrupt flags, a set beats a clear in the same cycle
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_first_timer_irq_flag <= 1'b0;
			o_second_timer_irq_flag <= 1'b0;
		end else begin
			if (wrap_w[0]) begin
				o_first_timer_irq_flag <= 1'b1;
			end else if (clear_r[0] || i_irq_ack[0]) begin
				o_first_timer_irq_flag <= 1'b0;
			end
			if (wrap_w[1]) begin
				o_second_timer_irq_flag <= 1'b1;
			end else if (clear_r[1] || i_irq_ack[1]) begin
				o_second_timer_irq_flag <= 1'b0;
			end
		end
	end

	// toggle output
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_first_timer_toggle_out <= 1'b1;
			o_toggle_out_oe_n <= 1'b1;
		end else begin
			o_toggle_out_oe_n <= ~toggle_out_select_r;
			if (clear_r[0]) begin
				o_first_timer_toggle_out <= 1'b1;
			end else if (wrap_w[0]) begin
				o_first_timer_toggle_out <= ~o_first_timer_toggle_out;
			end
		end
	end

	// register file reads
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_rf_rdata <= 4'h0;
		end else if (i_rf_rd) begin
			case (i_rf_addr)
				`DTC_RF_T0_MODE: o_rf_rdata <= mode_read(run_r[0],
					clksel_r[1:0]);
				`DTC_RF_T1_MODE: o_rf_rdata <= mode_read(run_r[1],
					clksel_r[3:2]);
				`DTC_RF_PORT_SEL: o_rf_rdata <= {toggle_out_select_r,
					3'h0};
				default: o_rf_rdata <= 4'h0;
			endcase
		end
	end

	// peripheral reads: counts only, modulo reads zero, count writes ignored
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_per_rdata <= 8'h00;
		end else if (i_per_rd) begin
			case (i_per_addr)
				`DTC_PER_CNT0: o_per_rdata <= count_w[7:0];
				`DTC_PER_CNT1: o_per_rdata <= count_w[15:8];
				default: o_per_rdata <= 8'h00;
			endcase
		end
	end
endmodule // dtc_timer_pair

// [verification/dtc_timer_pair_assertions.sv]
// assertions for the dual timer pair
`timescale 1ns/1ns
module dtc_sva (
	input wire logic i_clk, i_rst, i_rf_wr, i_rf_rd, i_per_rd,
	input wire logic [6:0] i_rf_addr,
	input wire logic [3:0] i_rf_wdata, o_rf_rdata,
	input wire logic [1:0] i_per_addr, i_irq_ack,
	input wire logic [7:0] o_per_rdata,
	input wire logic o_first_timer_irq_flag, o_first_timer_toggle_out,
	input wire logic o_toggle_out_oe_n
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	wire clr0 = i_rf_wr && i_rf_addr == 7'h11 && i_rf_wdata[2];
	sequence s_wr(a); i_rf_wr && !i_rf_rd && i_rf_addr == a; endsequence
	sequence s_rd(a); i_rf_rd && !i_rf_wr && i_rf_addr == a; endsequence
	property p_mode(a);
		s_wr(a) ##1 s_rd(a) |=> o_rf_rdata ==
			{$past(i_rf_wdata[3], 2), 1'b0, $past(i_rf_wdata[1:0], 2)};
	endproperty
	a_rst_state: assert property (disable iff (1'b0) i_rst |=>
		o_first_timer_toggle_out && o_toggle_out_oe_n && !o_first_timer_irq_flag)
		else $error("state after reset wrong");
	a_mod_wo: assert property (i_per_rd && !i_per_addr[1] |=>
		o_per_rdata == 8'h00) else $error("modulo read not zero");
	a_mode0_read: assert property (p_mode(7'h11))
		else $error("first mode readback wrong");
	a_mode1_read: assert property (p_mode(7'h12))
		else $error("second mode readback wrong");
	a_clr_reads0: assert property (s_rd(7'h11) |=> !o_rf_rdata[2])
		else $error("clear bit read as one");
	a_oe_select: assert property (s_wr(7'h0B) |=> ##1
		o_toggle_out_oe_n == !$past(i_rf_wdata[3], 2))
		else $error("output enable wrong");
	a_clr_toggle: assert property (clr0 |=> ##1 o_first_timer_toggle_out)
		else $error("clear did not set output");
	a_flag_hold: assert property (o_first_timer_irq_flag && !i_irq_ack[0]
		&& !clr0 && !$past(clr0) |=> o_first_timer_irq_flag)
		else $error("flag dropped by itself");
	a_toggle_match: assert property ($fell(o_first_timer_toggle_out)
		|-> o_first_timer_irq_flag) else $error("toggle without match");
endmodule // dtc_sva
bind dtc_timer_pair dtc_sva i_dtc_sva (.*);

// [verification/tb_top.sv]
// self-checking bench for the dual timer pair
`timescale 1ns/1ns
module tb_top;
	logic i_clk = 0, i_rst = 1, i_rf_wr = 0, i_rf_rd = 0, i_per_wr = 0;
	logic i_per_rd = 0, i_int_pin = 0, look = 0;
	logic [6:0] i_rf_addr = 0;
	logic [3:0] i_rf_wdata = 0, o_rf_rdata;
	logic [1:0] i_per_addr = 0, i_irq_ack = 0;
	logic [7:0] i_per_wdata = 0, o_per_rdata, n;
	logic o_first_timer_irq_flag, o_second_timer_irq_flag;
	logic o_first_timer_toggle_out, o_toggle_out_oe_n;
	logic [9:0] q[$];
	logic [9:0] e;
	logic [31:0] seed = 32'h12A2E55A;
	int n_fail = 0, total_checks = 0, cyc = 0;
	string nm[3] = '{"rf_rdata", "per_rdata", "pin_levels"};
	dtc_timer_pair i_dtc_timer_pair (.*);
	always #25 i_clk = ~i_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input string w, input logic [7:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", w, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			close_out();
		end
	end
	// outputs are settled half a cycle after the launching edge
	always @(negedge i_clk) begin
		if (look) begin
			e = q.pop_front();
			check(nm[e[9:8]], e[9:8] == 0 ? {4'h0, o_rf_rdata} : e[9:8] == 1 ?
				o_per_rdata : {4'h0, o_toggle_out_oe_n,
				o_first_timer_toggle_out, o_second_timer_irq_flag,
				o_first_timer_irq_flag}, e[7:0]);
		end
	end
	// strobes stay up between back-to-back transfers, dropped here
	task automatic tick(input int k);
		if (i_rf_wr | i_rf_rd | i_per_wr | i_per_rd)
			{i_rf_wr, i_rf_rd, i_per_wr, i_per_rd} = 4'h0;
		repeat (k) @(posedge i_clk);
		#5;
	endtask
	task automatic ex(input logic [1:0] s, input logic [7:0] v);
		q.push_back({s, v});
		look = 1;
		tick(1);
		look = 0;
	endtask
	task automatic rf(input logic [6:0] a, input logic [3:0] d, input logic w);
		if (i_per_wr | i_per_rd) {i_per_wr, i_per_rd} = 2'h0;
		i_rf_addr = a;
		i_rf_wdata = d;
		i_rf_wr = w;
		i_rf_rd = !w;
		@(posedge i_clk);
		#5;
	endtask
	task automatic per(input logic [1:0] a, input logic [7:0] d, input logic w);
		if (i_rf_wr | i_rf_rd) {i_rf_wr, i_rf_rd} = 2'h0;
		i_per_addr = a;
		i_per_wdata = d;
		i_per_wr = w;
		i_per_rd = !w;
		@(posedge i_clk);
		#5;
	endtask
	initial begin
		tick(6);
		i_rst = 0;
		rf(7'h11, 4'h0, 0);
		ex(0, 8'h00);
		rf(7'h12, 4'h0, 0);
		ex(0, 8'h00);
		rf(7'h05, 4'hF, 1);
		rf(7'h05, 4'h0, 0);
		ex(0, 8'h00);
		per(0, 8'hFF, 1);
		per(0, 8'h00, 0);
		ex(1, 8'h00);
		per(2, 8'h55, 1);
		per(2, 8'h00, 0);
		ex(1, 8'h00);
		for (int s = 0; s < 3; s++) begin
			rf(7'h11, 4'h4, 1);
			tick(2);
			rf(7'h11, {2'b10, s[1:0]}, 1);
			rf(7'h11, 4'h0, 0);
			ex(0, {6'h02, s[1:0]});
			tick(2 * (256 >> (2 * s)) - 3);
			rf(7'h11, {2'b00, s[1:0]}, 1);
			rf(7'h11, 4'h0, 0);
			ex(0, {6'h00, s[1:0]});
			per(2, 8'h00, 0);
			ex(1, 8'h02);
		end
		seed = lfsr(seed);
		n = {6'h00, seed[1:0]} + 8'h01;
		rf(7'h11, 4'h4, 1);
		rf(7'h11, 4'hB, 1);
		repeat (n) begin
			i_int_pin = 1;
			tick(2);
			i_int_pin = 0;
			tick(2);
		end
		rf(7'h11, 4'h3, 1);
		per(2, 8'h00, 0);
		ex(1, n);
		rf(7'h0B, 4'h8, 1);
		tick(2);
		ex(2, 8'h04);
		per(0, 8'h00, 1);
		per(1, 8'hFF, 1);
		rf(7'h12, 4'h4, 1);
		rf(7'h12, 4'hB, 1);
		rf(7'h12, 4'h0, 0);
		rf(7'h11, 4'h4, 1);
		rf(7'h11, 4'hA, 1);
		tick(16 * n - 1);
		rf(7'h11, 4'h2, 1);
		tick(3);
		per(3, 8'h00, 0);
		ex(1, n);
		ex(2, {5'h00, ~n[0], 2'b01});
		rf(7'h12, 4'h0, 0);
		ex(0, 8'h0B);
		i_irq_ack = 2'h1;
		tick(1);
		i_irq_ack = 2'h0;
		ex(2, {5'h00, ~n[0], 2'b00});
		rf(7'h11, 4'hB, 1);
		i_int_pin = 1;
		tick(2);
		i_int_pin = 0;
		rf(7'h11, 4'h3, 1);
		tick(1);
		ex(2, {5'h00, n[0], 2'b01});
		rf(7'h11, 4'h4, 1);
		tick(2);
		ex(2, 8'h04);
		per(2, 8'h00, 0);
		ex(1, 8'h00);
		rf(7'h12, 4'h4, 1);
		tick(2);
		per(3, 8'h00, 0);
		ex(1, 8'h00);
		rf(7'h0B, 4'h0, 1);
		tick(2);
		ex(2, 8'h0C);
		close_out();
	end
endmodule // tb_top
